// *** hdl/fsh_map.svh ***
// offsets, field positions, codes and timings of the flash command controller
`ifndef FSH_MAP_SVH
`define FSH_MAP_SVH
// avalon word offsets
`define FSH_REG_CTRL 3'h0
`define FSH_REG_CMD 3'h1
`define FSH_REG_ADDR 3'h2
`define FSH_REG_WDATA 3'h3
`define FSH_REG_STATUS 3'h4
`define FSH_REG_RDATA 3'h5
// ctrl fields and reset values
`define FSH_CTRL_BYTE 0
`define FSH_CTRL_FRST 1
`define FSH_CTRL_RESET 2'h2
// operation codes written to cmd
`define FSH_OP_READ 3'h1
`define FSH_OP_WRITE 3'h2
`define FSH_OP_SUSPEND 3'h3
`define FSH_OP_RESUME 3'h4
`define FSH_OP_EES 3'h5
`define FSH_OP_CONT 3'h6
// status fields
`define FSH_ST_BUSY 0
`define FSH_ST_SUSP 1
`define FSH_ST_REFUSED 2
`define FSH_ST_EES_DONE 3
`define FSH_ST_EES_BAD 4
`define FSH_ST_CONT_DONE 5
`define FSH_ST_CONT_PASS 6
`define FSH_ST_READY 7
`define FSH_ST_GAP_OK 8
// device command codes
`define FSH_CMD_SUSPEND 16'h00B0
`define FSH_CMD_RESUME 16'h0030
`define FSH_CMD_EES 16'h0035
`define FSH_CMD_SR_READ 16'h0070
`define FSH_CMD_SR_CLEAR 16'h0071
// device status bits
`define FSH_SR_READY 7
`define FSH_SR_NOT_ERASED 5
`define FSH_SR_CONT 0
// command addresses and continuity patterns
`define FSH_X16_CMD_ADDR 23'h000555
`define FSH_X8_CMD_ADDR 23'h000AAA
`define FSH_X16_PAT1_ADDR 23'h2AAA55
`define FSH_X16_PAT2_ADDR 23'h1555AA
`define FSH_X16_PAT1_DATA 16'hFF00
`define FSH_X16_PAT2_DATA 16'h00FF
`define FSH_X8_PAT1_ADDR 23'h5554AB
`define FSH_X8_PAT2_ADDR 23'h2AAB54
`define FSH_X8_PAT1_DATA 16'h00FF
`define FSH_X8_PAT2_DATA 16'h0000
// timing
`define FSH_CLK_NS 10
`define FSH_T_WP_NS 35
`define FSH_T_WPH_NS 20
`define FSH_T_ACC_NS 70
`define FSH_T_ERS_NS 100000
`define FSH_WP_CYC ((`FSH_T_WP_NS + `FSH_CLK_NS - 1) / `FSH_CLK_NS)
`define FSH_WPH_CYC ((`FSH_T_WPH_NS + `FSH_CLK_NS - 1) / `FSH_CLK_NS)
`define FSH_ACC_CYC (((`FSH_T_ACC_NS + `FSH_CLK_NS - 1) / `FSH_CLK_NS) + 2)
`define FSH_ERS_CYC ((`FSH_T_ERS_NS + `FSH_CLK_NS - 1) / `FSH_CLK_NS)
`endif

// *** hdl/fsh_pkg.sv ***
// types of the flash command controller
`default_nettype none
package fsh_pkg;
  typedef enum logic [2:0] {S_IDLE, S_SETUP, S_PULSE, S_HOLD, S_READ} fsh_state_t;

  typedef struct packed {
    logic rd;
    logic [22:0] a;
    logic [15:0] d;
  } fsh_spec_t;

  typedef struct packed {
    fsh_state_t st;
    logic [2:0] op;
    logic [2:0] step;
    logic [7:0] cnt;
    logic [15:0] gap;
    logic susp;
    logic refused;
    logic ees_done;
    logic ees_bad;
    logic cont_done;
    logic cont_pass;
    logic [1:0] ctrl;
    logic [22:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [31:0] av_rdata;
    logic av_rvalid;
    logic [22:0] pin_a;
    logic [15:0] dq_o;
    logic dq_oe;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [15:0] dq_s1;
    logic [15:0] dq_s2;
    logic rdy_s1;
    logic rdy_s2;
  } fsh_regs_t;
endpackage : fsh_pkg
`default_nettype wire

// *** hdl/fsh_ctrl.sv ***
// host-side command controller for a parallel nor flash, avalon-mm slave toward software
// Notes on behaviour
// - resume needed to continue; repeated resumes ignored; suspend again only after resume.
// - host leaves the minimum resume-to-suspend gap before suspending again.
// - erase-state check starts by writing 35h into the sector while idle.
// - no erase-state check while programming, erasing or suspended.
// - host polls ready bit and reports a not-erased sector for re-erase.
// - word mode continuity: clear, confirm zero, FF00@2AAA55, 00FF@1555AA, expect one.
// - byte mode uses AAA for commands and FF@5554AB, 00@2AAB54.
// - resume is code 30h with address ignored.
`default_nettype none
`include "fsh_map.svh"
module fsh_ctrl #(
  parameter int RESUME_GAP_CYC = `FSH_ERS_CYC
) (
  input wire logic clk_sys, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic [2:0] av_address, // avalon word address
  input wire logic av_read, // avalon read
  input wire logic av_write, // avalon write
  input wire logic [31:0] av_writedata, // avalon write data
  output logic [31:0] av_readdata, // avalon read data
  output logic av_waitrequest, // avalon wait
  output logic [21:0] flash_addr, // flash address lines
  output logic flash_addr_lsb, // extra low address line in byte mode
  output logic [15:0] flash_dq_out, // flash data out
  output logic flash_dq_oe, // flash data drive enable
  input wire logic [15:0] flash_dq_in, // flash data in
  output logic flash_ce_n, // chip enable
  output logic flash_oe_n, // output enable
  output logic flash_we_n, // write enable
  output logic flash_byte_n, // low selects byte mode
  output logic flash_rst_n, // flash hardware reset
  input wire logic flash_ready // ready/busy pin, high when ready
);
  // the gap counter is 16 bits wide and must load a nonzero value
  if (RESUME_GAP_CYC < 1 || RESUME_GAP_CYC > 65535) begin : gen_gap_check
    $error("RESUME_GAP_CYC out of range");
  end

  fsh_pkg::fsh_regs_t r_ff;
  fsh_pkg::fsh_regs_t nxt_r;
  fsh_pkg::fsh_spec_t spec;

  // cycle to issue for the current operation step
  function automatic fsh_pkg::fsh_spec_t step_spec(input logic [2:0] op, input logic [2:0] step,
      input logic bm, input logic [22:0] addr, input logic [15:0] wdata);
    fsh_pkg::fsh_spec_t s;
    logic [22:0] ca;
    s = '0;
    ca = bm ? `FSH_X8_CMD_ADDR : `FSH_X16_CMD_ADDR;
    s.a = ca;
    case (op)
      `FSH_OP_READ: begin
        s.rd = 1'b1;
        s.a = addr;
      end
      `FSH_OP_WRITE: begin
        s.a = addr;
        s.d = wdata;
      end
      `FSH_OP_SUSPEND: begin
        s.a = addr;
        s.d = `FSH_CMD_SUSPEND;
      end
      `FSH_OP_RESUME: begin
        s.a = addr;
        s.d = `FSH_CMD_RESUME;
      end
      `FSH_OP_EES: begin
        case (step)
          3'h0: begin
            s.a = addr;
            s.d = `FSH_CMD_EES;
          end
          3'h1: s.d = `FSH_CMD_SR_READ;
          default: s.rd = 1'b1;
        endcase
      end
      `FSH_OP_CONT: begin
        case (step)
          3'h0: s.d = `FSH_CMD_SR_CLEAR;
          3'h1: s.d = `FSH_CMD_SR_READ;
          3'h2: s.rd = 1'b1;
          3'h3: begin
            s.a = bm ? `FSH_X8_PAT1_ADDR : `FSH_X16_PAT1_ADDR;
            s.d = bm ? `FSH_X8_PAT1_DATA : `FSH_X16_PAT1_DATA;
          end
          3'h4: begin
            s.a = bm ? `FSH_X8_PAT2_ADDR : `FSH_X16_PAT2_ADDR;
            s.d = bm ? `FSH_X8_PAT2_DATA : `FSH_X16_PAT2_DATA;
          end
          3'h5: s.d = `FSH_CMD_SR_READ;
          default: s.rd = 1'b1;
        endcase
      end
      default: s = '0;
    endcase
    return s;
  endfunction : step_spec

  always_comb begin
    logic [2:0] op_w;
    logic bm;
    logic fin;
    op_w = av_writedata[2:0];
    bm = r_ff.ctrl[`FSH_CTRL_BYTE];
    fin = 1'b0;
    nxt_r = r_ff;
    spec = step_spec(r_ff.op, r_ff.step, bm, r_ff.addr, r_ff.wdata);
    nxt_r.dq_s1 = flash_dq_in;
    nxt_r.dq_s2 = r_ff.dq_s1;
    nxt_r.rdy_s1 = flash_ready;
    nxt_r.rdy_s2 = r_ff.rdy_s1;
    if (r_ff.gap != 16'h0) begin
      nxt_r.gap = r_ff.gap - 16'h1;
    end
    // avalon read: one wait cycle, data registered
    nxt_r.av_rvalid = av_read & ~r_ff.av_rvalid;
    case (av_address)
      `FSH_REG_CTRL: nxt_r.av_rdata = {30'h0, r_ff.ctrl};
      `FSH_REG_ADDR: nxt_r.av_rdata = {9'h0, r_ff.addr};
      `FSH_REG_WDATA: nxt_r.av_rdata = {16'h0, r_ff.wdata};
      `FSH_REG_STATUS: nxt_r.av_rdata = {23'h0, r_ff.gap == 16'h0, r_ff.rdy_s2,
          r_ff.cont_pass, r_ff.cont_done, r_ff.ees_bad, r_ff.ees_done, r_ff.refused,
          r_ff.susp, r_ff.st != fsh_pkg::S_IDLE};
      `FSH_REG_RDATA: nxt_r.av_rdata = {16'h0, r_ff.rdata};
      default: nxt_r.av_rdata = 32'h0;
    endcase
    if (av_write) begin
      case (av_address)
        `FSH_REG_CTRL: nxt_r.ctrl = av_writedata[1:0];
        `FSH_REG_ADDR: nxt_r.addr = av_writedata[22:0];
        `FSH_REG_WDATA: nxt_r.wdata = av_writedata[15:0];
        `FSH_REG_CMD: begin
          nxt_r.refused = 1'b0;
          if (r_ff.st != fsh_pkg::S_IDLE) begin
            nxt_r.refused = 1'b1;
          // suspend only while not suspended, resume only while suspended
          end else if ((op_w == `FSH_OP_SUSPEND && (r_ff.susp || r_ff.gap != 16'h0))
              || (op_w == `FSH_OP_RESUME && !r_ff.susp)
              // check refused while busy or suspended
              || (op_w == `FSH_OP_EES && (r_ff.susp || !r_ff.rdy_s2))
              || op_w == 3'h0 || op_w == 3'h7) begin
            nxt_r.refused = 1'b1;
          end else begin
            nxt_r.op = op_w;
            nxt_r.step = 3'h0;
            nxt_r.st = fsh_pkg::S_SETUP;
            if (op_w == `FSH_OP_EES) begin
              nxt_r.ees_done = 1'b0;
              nxt_r.ees_bad = 1'b0;
            end
            if (op_w == `FSH_OP_CONT) begin
              nxt_r.cont_done = 1'b0;
              nxt_r.cont_pass = 1'b0;
            end
          end
        end
        default: ;
      endcase
    end
    case (r_ff.st)
      fsh_pkg::S_IDLE: begin
        nxt_r.ce_n = 1'b1;
        nxt_r.oe_n = 1'b1;
        nxt_r.we_n = 1'b1;
        nxt_r.dq_oe = 1'b0;
      end
      fsh_pkg::S_SETUP: begin
        nxt_r.pin_a = spec.a;
        nxt_r.dq_o = spec.d;
        nxt_r.dq_oe = ~spec.rd;
        nxt_r.ce_n = 1'b0;
        if (spec.rd) begin
          nxt_r.oe_n = 1'b0;
          nxt_r.cnt = 8'(`FSH_ACC_CYC - 1);
          nxt_r.st = fsh_pkg::S_READ;
        end else begin
          nxt_r.we_n = 1'b0;
          nxt_r.cnt = 8'(`FSH_WP_CYC - 1);
          nxt_r.st = fsh_pkg::S_PULSE;
        end
      end
      fsh_pkg::S_PULSE: begin
        if (r_ff.cnt == 8'h0) begin
          nxt_r.we_n = 1'b1;
          nxt_r.cnt = 8'(`FSH_WPH_CYC - 1);
          nxt_r.st = fsh_pkg::S_HOLD;
        end else begin
          nxt_r.cnt = r_ff.cnt - 8'h1;
        end
      end
      fsh_pkg::S_HOLD: begin
        if (r_ff.cnt == 8'h0) begin
          nxt_r.ce_n = 1'b1;
          nxt_r.dq_oe = 1'b0;
          fin = (r_ff.op != `FSH_OP_EES && r_ff.op != `FSH_OP_CONT);
          nxt_r.step = r_ff.step + 3'h1;
          nxt_r.st = fsh_pkg::S_SETUP;
          if (r_ff.op == `FSH_OP_SUSPEND) begin
            nxt_r.susp = 1'b1;
          end
          if (r_ff.op == `FSH_OP_RESUME) begin
            nxt_r.susp = 1'b0;
            nxt_r.gap = 16'(RESUME_GAP_CYC);
          end
        end else begin
          nxt_r.cnt = r_ff.cnt - 8'h1;
        end
      end
      fsh_pkg::S_READ: begin
        if (r_ff.cnt == 8'h0) begin
          nxt_r.ce_n = 1'b1;
          nxt_r.oe_n = 1'b1;
          nxt_r.rdata = r_ff.dq_s2;
          nxt_r.step = r_ff.step + 3'h1;
          nxt_r.st = fsh_pkg::S_SETUP;
          fin = (r_ff.op == `FSH_OP_READ);
          if (r_ff.op == `FSH_OP_EES) begin
            // poll ready bit, then latch not-erased result
            if (r_ff.dq_s2[`FSH_SR_READY]) begin
              fin = 1'b1;
              nxt_r.ees_done = 1'b1;
              nxt_r.ees_bad = r_ff.dq_s2[`FSH_SR_NOT_ERASED];
            end else begin
              nxt_r.step = 3'h1;
            end
          end
          // bit 0 must read zero after clear and one after patterns
          if (r_ff.op == `FSH_OP_CONT) begin
            if (r_ff.step == 3'h2 && r_ff.dq_s2[`FSH_SR_CONT]) begin
              fin = 1'b1;
              nxt_r.cont_done = 1'b1;
            end else if (r_ff.step != 3'h2) begin
              fin = 1'b1;
              nxt_r.cont_done = 1'b1;
              nxt_r.cont_pass = r_ff.dq_s2[`FSH_SR_CONT];
            end
          end
        end else begin
          nxt_r.cnt = r_ff.cnt - 8'h1;
        end
      end
      default: nxt_r.st = fsh_pkg::S_IDLE;
    endcase
    if (fin) begin
      nxt_r.st = fsh_pkg::S_IDLE;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      r_ff <= '0;
      r_ff.st <= fsh_pkg::S_IDLE;
      r_ff.ctrl <= `FSH_CTRL_RESET;
      r_ff.ce_n <= 1'b1;
      r_ff.oe_n <= 1'b1;
      r_ff.we_n <= 1'b1;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign av_readdata = r_ff.av_rdata;
  assign av_waitrequest = av_read & ~r_ff.av_rvalid;
  // byte mode splits the byte address onto the extra low line
  assign flash_addr = r_ff.ctrl[`FSH_CTRL_BYTE] ? r_ff.pin_a[22:1] : r_ff.pin_a[21:0];
  assign flash_addr_lsb = r_ff.ctrl[`FSH_CTRL_BYTE] & r_ff.pin_a[0];
  assign flash_dq_out = r_ff.dq_o;
  assign flash_dq_oe = r_ff.dq_oe;
  assign flash_ce_n = r_ff.ce_n;
  assign flash_oe_n = r_ff.oe_n;
  assign flash_we_n = r_ff.we_n;
  assign flash_byte_n = ~r_ff.ctrl[`FSH_CTRL_BYTE];
  assign flash_rst_n = r_ff.ctrl[`FSH_CTRL_FRST];
endmodule : fsh_ctrl
`default_nettype wire

// *** testbench/fsh_checker.sv ***
// pin and bus timing checks for the flash command controller
`default_nettype none
module fsh_checker (
  input wire logic clk_sys, // clock
  input wire logic nrst, // reset, active low
  input wire logic av_read, // avalon read
  input wire logic av_write, // avalon write
  input wire logic av_waitrequest, // avalon wait
  input wire logic [21:0] flash_addr, // address lines
  input wire logic flash_addr_lsb, // byte lane line
  input wire logic [15:0] flash_dq_out, // data out
  input wire logic flash_dq_oe, // data drive
  input wire logic flash_ce_n, // chip enable
  input wire logic flash_oe_n, // output enable
  input wire logic flash_we_n, // write enable
  input wire logic flash_byte_n // word mode when high
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  rw_excl_a: assert property (!(!flash_we_n && !flash_oe_n))
    else $error("write and read strobes low together");
  we_in_ce_a: assert property (!flash_we_n |-> !flash_ce_n && flash_dq_oe)
    else $error("write strobe without select or drive");
  rd_release_a: assert property (!flash_oe_n |-> !flash_dq_oe && !flash_ce_n)
    else $error("data driven during a read");
  rd_wait_a: assert property (av_read && av_waitrequest |=> !av_waitrequest)
    else $error("read waits more than one cycle");
  wr_nowait_a: assert property (av_write |-> !av_waitrequest)
    else $error("write was held off");
  wait_cause_a: assert property (av_waitrequest |-> av_read)
    else $error("wait without a read");
  we_width_a: assert property ($fell(flash_we_n) |-> (!flash_we_n)[*4] ##1 flash_we_n)
    else $error("write strobe width wrong");
  pat_stable_a: assert property (
    !flash_we_n && !$past(flash_we_n) |-> $stable(flash_addr) && $stable(flash_dq_out))
    else $error("address or data moved under write strobe");
  hold_data_a: assert property (
    $rose(flash_we_n) |-> (!flash_ce_n && flash_dq_oe && $stable(flash_dq_out))[*2])
    else $error("data not held after write strobe");
  lsb_word_a: assert property (!flash_ce_n && flash_byte_n |-> !flash_addr_lsb)
    else $error("byte lane line set in word mode");
  cover property ($fell(flash_we_n) && flash_dq_out == 16'h00B0);
  cover property ($fell(flash_we_n) && flash_dq_out == 16'h0030);
  cover property ($fell(flash_we_n) && flash_dq_out == 16'h0035);
  cover property ($fell(flash_we_n) && flash_dq_out == 16'h0071);
endmodule : fsh_checker
bind fsh_ctrl fsh_checker i_fsh_checker (.clk_sys(clk_sys), .nrst(nrst), .av_read(av_read),
  .av_write(av_write), .av_waitrequest(av_waitrequest), .flash_addr(flash_addr),
  .flash_addr_lsb(flash_addr_lsb), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
  .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
  .flash_byte_n(flash_byte_n));
`default_nettype wire

// *** testbench/fsh_flash_model.sv ***
// behavioural parallel nor flash seen at its pins
`default_nettype none
module fsh_flash_model #(
  parameter int LAT_NS = 300,
  parameter int TO_NS = 300,
  parameter int CHK_NS = 400
) (
  input wire logic [21:0] a, // address
  input wire logic a_lsb, // byte lane address
  input wire logic [15:0] d_o, // host data
  input wire logic ce_n, // chip enable
  input wire logic oe_n, // output enable
  input wire logic we_n, // write enable
  input wire logic byte_n, // word mode when high
  input wire logic rst_n, // hardware reset
  input wire logic erase_go, // starts an erase of sector 0
  input wire logic bad, // sector 0 not fully erased
  input wire logic fault, // breaks the first pattern cycle
  output logic [15:0] dq, // data to host
  output logic ready // ready pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ers = 1'b0;
  logic susp = 1'b0;
  logic chk = 1'b0;
  logic stm = 1'b0;
  logic tgl = 1'b0;
  logic p1 = 1'b0;
  logic cont = 1'b0;
  logic nz = 1'b0;
  time t0 = 0;
  logic [22:0] wa;
  logic [15:0] val;
  logic w1;
  logic w2;
  assign wa = byte_n ? {1'b0, a} : {a, a_lsb};
  assign w1 = wa == (byte_n ? 23'h2AAA55 : 23'h5554AB)
    && (byte_n ? d_o == 16'hFF00 : d_o[7:0] == 8'hFF);
  assign w2 = wa == (byte_n ? 23'h1555AA : 23'h2AAB54)
    && (byte_n ? d_o == 16'h00FF : d_o[7:0] == 8'h00);
  assign ready = !(ers && !susp) && !chk;
  assign val = stm ? {8'h00, ready, 1'b0, nz, 4'h0, cont} : chk ? {16{tgl}} :
    (ers && a[21:15] == 7'h00) ? {8'h00, susp, ~susp & tgl, 3'h0, tgl, 2'h0} : a[15:0] ^ 16'h5A5A;
  // released bus shows the inverse
  assign dq = (!ce_n && !oe_n) ? val : ~val;
  always @(posedge oe_n) begin
    stm = 1'b0;
    tgl = ~tgl;
  end
  always @(posedge we_n or posedge erase_go or negedge rst_n) begin
    if (!rst_n) begin
      ers = 1'b0;
      susp = 1'b0;
    end else if (erase_go && !ers) begin
      ers = 1'b1;
      t0 = $time;
    end else if (!ce_n) begin
      // other writes leave the suspended state as it is
      if (d_o[7:0] == 8'hB0 && ers && !susp) begin
        if ($time - t0 < TO_NS) susp = 1'b1;
        else susp <= #(LAT_NS) 1'b1;
      end
      if (d_o[7:0] == 8'h30 && susp) begin
        susp = 1'b0;
        t0 = $time - TO_NS;
      end
      if (d_o[7:0] == 8'h35 && !ers && !chk) begin
        chk = 1'b1;
        nz = bad;
        chk <= #(CHK_NS) 1'b0;
      end
      if (d_o[7:0] == 8'h71) cont = 1'b0;
      if (d_o[7:0] == 8'h70) stm = 1'b1;
      if (p1 && w2) cont = 1'b1;
      p1 = w1 && !fault;
    end
  end
endmodule : fsh_flash_model
`default_nettype wire

// *** testbench/fsh_ctrl_tb.sv ***
// self-checking bench of the flash command controller
`default_nettype none
module fsh_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, nrst, av_read, av_write, av_waitrequest, flash_addr_lsb, flash_dq_oe;
  logic flash_ce_n, flash_oe_n, flash_we_n, flash_byte_n, flash_rst_n, flash_ready;
  logic erase_go, bad, fault;
  logic [2:0] av_address;
  logic [31:0] av_writedata, av_readdata, s, d, seed;
  logic [21:0] flash_addr;
  logic [15:0] flash_dq_out, flash_dq_in;
  int num_errors = 0;
  int num_checks = 0;
  fsh_ctrl #(.RESUME_GAP_CYC(20)) i_fsh_ctrl (.clk_sys(clk_sys), .nrst(nrst),
    .av_address(av_address), .av_read(av_read), .av_write(av_write),
    .av_writedata(av_writedata), .av_readdata(av_readdata), .av_waitrequest(av_waitrequest),
    .flash_addr(flash_addr), .flash_addr_lsb(flash_addr_lsb), .flash_dq_out(flash_dq_out),
    .flash_dq_oe(flash_dq_oe), .flash_dq_in(flash_dq_in), .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .flash_byte_n(flash_byte_n),
    .flash_rst_n(flash_rst_n), .flash_ready(flash_ready));
  fsh_flash_model i_fsh_flash_model (.a(flash_addr), .a_lsb(flash_addr_lsb),
    .d_o(flash_dq_out), .ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n),
    .byte_n(flash_byte_n), .rst_n(flash_rst_n), .erase_go(erase_go), .bad(bad),
    .fault(fault), .dq(flash_dq_in), .ready(flash_ready));
  always #5 clk_sys = ~clk_sys;
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  task automatic print_verdict;
    if (num_errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  task automatic wait_ack;
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (av_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      num_errors++;
      print_verdict();
    end
  endtask : wait_ack
  task automatic av_wr(input logic [2:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    av_address <= a;
    av_writedata <= v;
    av_write <= 1'b1;
    wait_ack();
    av_write <= 1'b0;
  endtask : av_wr
  task automatic av_rd(input logic [2:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    av_address <= a;
    av_read <= 1'b1;
    wait_ack();
    v = av_readdata;
    av_read <= 1'b0;
  endtask : av_rd
  // polls status until the bit holds the level or the bound runs out
  task automatic poll(input int b, input logic lv, output logic [31:0] v);
    int n;
    n = 0;
    do begin
      av_rd(3'h4, v);
      n++;
    end while (v[b] !== lv && n < 300);
    if (n >= 300) begin
      num_errors++;
      print_verdict();
    end
  endtask : poll
  task automatic op(input logic [2:0] c, output logic [31:0] v);
    av_wr(3'h1, {29'h0, c});
    poll(0, 1'b0, v);
  endtask : op
  task automatic chk_st(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: status bit %b not %b", $time, got, exp);
    end
  endtask : chk_st
  task automatic chk_rd(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: read %h not %h", $time, got, exp);
    end
  endtask : chk_rd
  initial begin
    clk_sys = 1'b0;
    nrst = 1'b0;
    av_address = 3'h0;
    av_read = 1'b0;
    av_write = 1'b0;
    av_writedata = 32'h0;
    erase_go = 1'b0;
    bad = 1'b0;
    fault = 1'b0;
    seed = 32'h9DA3;
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    av_rd(3'h4, s);
    chk_st(s[0], 1'b0);
    av_rd(3'h6, s);
    chk_rd(s[15:0], 16'h0000);
    for (int i = 0; i < 3; i++) begin
      fault <= (i == 2);
      av_wr(3'h0, {30'h0, 1'b1, i == 1});
      op(3'h6, s);
      chk_st(s[5], 1'b1);
      chk_st(s[6], i != 2);
    end
    av_wr(3'h0, 32'h2);
    for (int i = 0; i < 2; i++) begin
      seed = lfsr(seed);
      bad <= i[0];
      av_wr(3'h2, {17'h0, seed[14:0]});
      op(3'h5, s);
      chk_st(s[3], 1'b1);
      chk_st(s[4], i[0]);
    end
    for (int j = 0; j < 2; j++) begin
      av_wr(3'h0, 32'h0);
      av_wr(3'h0, 32'h2);
      erase_go <= 1'b1;
      @(posedge clk_sys);
      erase_go <= 1'b0;
      repeat (40 * j) @(posedge clk_sys);
      op(3'h3, s);
      chk_st(s[1], 1'b1);
      av_rd(3'h4, s);
      chk_st(s[7], j == 0);
      poll(7, 1'b1, s);
      seed = lfsr(seed);
      av_wr(3'h2, {17'h0, seed[14:0]});
      op(3'h1, s);
      av_rd(3'h5, d);
      chk_rd(d[15:0] & 16'h00C0, 16'h0080);
      av_wr(3'h2, {17'h1, seed[14:0]});
      op(3'h1, s);
      av_rd(3'h5, d);
      chk_rd(d[15:0], {1'b1, seed[14:0]} ^ 16'h5A5A);
      av_wr(3'h3, {16'h0, seed[31:24], 8'h5A});
      op(3'h2, s);
      av_wr(3'h2, {17'h0, seed[14:0]});
      op(3'h1, s);
      av_rd(3'h5, d);
      chk_rd(d[15:0] & 16'h00C0, 16'h0080);
      op(3'h5, s);
      chk_st(s[2], 1'b1);
      op(3'h3, s);
      chk_st(s[2], 1'b1);
      op(3'h4, s);
      chk_st(s[1], 1'b0);
      op(3'h4, s);
      chk_st(s[2], 1'b1);
      op(3'h3, s);
      chk_st(s[2] & ~s[8], 1'b1);
      repeat (25) @(posedge clk_sys);
      op(3'h3, s);
      chk_st(s[1] & ~s[2], 1'b1);
      poll(7, 1'b1, s);
      op(3'h4, s);
    end
    print_verdict();
  end
endmodule : fsh_ctrl_tb
`default_nettype wire
